//--- rtl/gpib_message_responder.sv
`timescale 1ns/1ps
`include "gmr_consts.svh"

module gpib_message_responder #(
	parameter logic [4:0] DEFAULT_ADDR = `GMR_R_ADDR
) (
	input  wire logic              core_clk,    // 250 MHz clock
	input  wire logic              rst_b,       // async reset, low
	input  wire logic              wb_cyc_i,    // bus cycle
	input  wire logic              wb_stb_i,    // strobe
	input  wire logic              wb_we_i,     // write
	input  wire logic [4:0]        wb_adr_i,    // byte address
	input  wire logic [3:0]        wb_sel_i,    // byte lanes
	input  wire logic [31:0]       wb_dat_i,    // write data
	output logic [31:0]            wb_dat_o,    // read data
	output logic                   wb_ack_o,    // acknowledge
	output logic                   irq,         // level interrupt
	input  wire gmr_pkg::gpib_in_t gpibIn,      // bus lines, true high
	output logic [7:0]             dioOut,      // data lines driven
	output logic [7:0]             dioOe,       // per-line enable
	output logic                   davOut,      // data valid as talker
	output logic                   eoiOut,      // end of message
	output logic                   accOut,      // byte accepted
	output logic                   srqOut,      // service request
	input  wire logic              srvReq,      // instrument wants service
	input  wire logic [5:0]        statIn,      // instrument status bits
	input  wire logic              seqProgrammed, // stored sequence exists
	output logic                   devClr,      // reset instrument pulse
	output logic                   trigRun,     // run sequence pulse
	output logic                   remoteMode,  // under remote control
	output logic                   lockout,     // local key disabled
	output logic [7:0]             rxData,      // received data byte
	output logic                   rxValid,     // rxData pulse
	output logic                   rxLang       // 1 routes to SCPI parser
);

	// A default address outside the legal range would leave the device unreachable after reset.
	if (DEFAULT_ADDR < `GMR_ADDR_MIN || DEFAULT_ADDR > `GMR_ADDR_MAX) begin : g_addr_check
		$error("DEFAULT_ADDR out of range");
	end

	gmr_pkg::state_t q;
	gmr_pkg::state_t n;

	////////////////////////////////////////////////////////////////////////////
	// Decoded views of synchronised bus lines, register bus requests and the talker byte.

	logic       byteNew;
	logic [6:0] code;
	logic       cmdNew;
	logic       ppoll;
	logic       wbReq;
	logic       wbWr;
	logic [7:0] curByte;
	logic [5:0] ev;
	logic [5:0] w1c;

	assign byteNew = q.s2.dav & ~q.s3.dav;
	assign code    = q.s2.dio[6:0];
	assign cmdNew  = byteNew & q.s2.atn;
	assign ppoll   = q.s2.atn & q.s2.eoi;
	assign wbReq   = wb_cyc_i & wb_stb_i & ~q.ack;
	assign wbWr    = wbReq & wb_we_i;

	always_comb begin
		curByte = q.txByte;
		unique case (q.txPh)
			gmr_pkg::TX_IDLE: curByte = 8'h00;
			gmr_pkg::TX_DATA: curByte = q.txByte;
			gmr_pkg::TX_CR:   curByte = `GMR_CR;
			gmr_pkg::TX_LF:   curByte = `GMR_LF;
			gmr_pkg::TX_STAT: curByte = {1'b0, srvReq, statIn};
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		n = q;
		ev = 6'h00;
		w1c = 6'h00;
		n.s1 = gpibIn;
		n.s2 = q.s1;
		n.s3 = q.s2;
		n.devClr = 1'b0;
		n.trig = 1'b0;
		n.rxValid = 1'b0;
		n.srq = srvReq;

		// Commands change only interface state, except the two clears and the group execute trigger.
		if (cmdNew) begin
			if (code == {2'b01, q.addr}) begin
				n.listen = 1'b1;
				if (q.s2.ren)
					n.remote = 1'b1;
			end
			if (code == `GMR_C_UNL)
				n.listen = 1'b0;
			if (code[6:5] == 2'b10) begin
				n.talk = (code[4:0] == q.addr);
				if (code[4:0] == q.addr)
					n.spSent = 1'b0;
			end
			if (code == `GMR_C_GTL && q.listen) begin
				n.remote = 1'b0;
				ev[`GMR_I_GTL] = 1'b1;
			end
			if (code == `GMR_C_DCL || (code == `GMR_C_SDC && q.listen)) begin
				n.devClr = 1'b1;
				ev[`GMR_I_CLR] = 1'b1;
			end
			if (code == `GMR_C_GET && q.listen && seqProgrammed) begin
				n.trig = 1'b1;
				ev[`GMR_I_TRIG] = 1'b1;
			end
			if (code == `GMR_C_LLO) begin
				n.lockout = 1'b1;
				ev[`GMR_I_LLO] = 1'b1;
			end
			if (code == `GMR_C_SPE)
				n.spMode = 1'b1;
			if (code == `GMR_C_SPD) begin
				n.spMode = 1'b0;
				n.spSent = 1'b0;
			end
			if (code == `GMR_C_PPU)
				n.ppCfg = 1'b0;
			// Enable or disable codes follow the configure command.
			n.ppPend = (code == `GMR_C_PPC) && q.listen;
			if (q.ppPend && code[6:4] == 3'b110) begin
				n.ppe = code[3:0];
				n.ppCfg = 1'b1;
			end
			if (q.ppPend && code == `GMR_C_PPD)
				n.ppCfg = 1'b0;
		end

		// Data bytes go to the selected parser.
		if (byteNew && !q.s2.atn && q.listen) begin
			n.rxData = q.s2.dio;
			n.rxValid = 1'b1;
		end

		if (byteNew && (q.s2.atn || q.listen))
			n.accOut = 1'b1;
		else if (!q.s2.dav)
			n.accOut = 1'b0;

		if (!q.s2.ren) begin
			n.remote = 1'b0;
			n.lockout = 1'b0;
		end

		// Talker byte sequencing.
		if (!q.talk || q.s2.atn) begin
			n.davOut = 1'b0;
		end else if (!q.davOut) begin
			if (q.txPh == gmr_pkg::TX_IDLE && q.spMode && !q.spSent)
				n.txPh = gmr_pkg::TX_STAT;
			else if (q.txPh != gmr_pkg::TX_IDLE && !q.s2.acc) begin
				n.davOut = 1'b1;
				n.dioOut = curByte;
				n.eoiOut = (q.txPh == gmr_pkg::TX_STAT) || (q.txPh == gmr_pkg::TX_LF) ||
				           (q.txPh == gmr_pkg::TX_CR && q.termCr);
			end
		end else if (q.s2.acc) begin
			n.davOut = 1'b0;
			n.eoiOut = 1'b0;
			unique case (q.txPh)
				gmr_pkg::TX_IDLE: n.txPh = gmr_pkg::TX_IDLE;
				gmr_pkg::TX_DATA: n.txPh = q.txLast ? gmr_pkg::TX_CR : gmr_pkg::TX_IDLE;
				gmr_pkg::TX_CR:   n.txPh = q.termCr ? gmr_pkg::TX_IDLE : gmr_pkg::TX_LF;
				gmr_pkg::TX_LF:   n.txPh = gmr_pkg::TX_IDLE;
				gmr_pkg::TX_STAT: begin
					n.txPh = gmr_pkg::TX_IDLE;
					n.spSent = 1'b1;
				end
			endcase
		end

		// Interface clear quiets the bus side only.
		if (q.s2.ifc) begin
			n.listen = 1'b0;
			n.talk = 1'b0;
			n.spMode = 1'b0;
			n.ppPend = 1'b0;
			n.davOut = 1'b0;
			n.eoiOut = 1'b0;
			n.txPh = gmr_pkg::TX_IDLE;
			ev[`GMR_I_IFC] = ~q.s3.ifc;
		end

		// Data lines: parallel poll answer overrides the talker.
		if (ppoll) begin
			n.dioOe = 8'h00;
			n.dioOut = 8'h00;
			if (q.ppCfg) begin
				n.dioOe[q.ppe[2:0]] = 1'b1;
				n.dioOut[q.ppe[2:0]] = (srvReq == q.ppe[3]);
			end
		end else if (n.davOut) begin
			n.dioOe = 8'hFF;
		end else begin
			n.dioOe = 8'h00;
		end

		// Register bus slave, one wait state.
		n.ack = wbReq;
		n.rdat = 32'h0000_0000;
		if (wbReq && !wb_we_i) begin
			unique case (wb_adr_i)
				`GMR_A_CTRL: n.rdat = {22'h0, q.lang, q.termCr, 3'h0, q.addr};
				`GMR_A_STAT: n.rdat = {25'h0, (q.txPh != gmr_pkg::TX_IDLE), q.ppCfg, q.spMode,
				                      q.talk, q.listen, q.lockout, q.remote};
				`GMR_A_IRQ:  n.rdat = {26'h0, q.irqSt};
				`GMR_A_MASK: n.rdat = {26'h0, q.irqMask};
				default:     n.rdat = 32'h0000_0000;
			endcase
		end
		if (wbWr && wb_adr_i == `GMR_A_CTRL) begin
			if (wb_sel_i[0]) begin
				if (wb_dat_i[4:0] >= `GMR_ADDR_MIN && wb_dat_i[4:0] <= `GMR_ADDR_MAX)
					n.addr = wb_dat_i[4:0];
				else
					ev[`GMR_I_REJ] = 1'b1;
			end
			if (wb_sel_i[1]) begin
				n.termCr = wb_dat_i[`GMR_F_TERM];
				n.lang = wb_dat_i[`GMR_F_LANG];
			end
		end
		if (wbWr && wb_adr_i == `GMR_A_IRQ && wb_sel_i[0])
			w1c = wb_dat_i[5:0];
		if (wbWr && wb_adr_i == `GMR_A_MASK && wb_sel_i[0])
			n.irqMask = wb_dat_i[5:0];
		// A response byte is taken only when the talker is idle.
		if (wbWr && wb_adr_i == `GMR_A_RESP && wb_sel_i[0] && q.txPh == gmr_pkg::TX_IDLE) begin
			n.txByte = wb_dat_i[7:0];
			n.txLast = wb_sel_i[1] & wb_dat_i[`GMR_F_LAST];
			n.txPh = gmr_pkg::TX_DATA;
		end

		// A new event wins over a clear in the same cycle.
		n.irqSt = (q.irqSt & ~w1c) | ev;
		n.irq = |(n.irqSt & n.irqMask);
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
			q.addr <= DEFAULT_ADDR;
			q.txPh <= gmr_pkg::TX_IDLE;
		end else begin
			q <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign wb_dat_o   = q.rdat;
	assign wb_ack_o   = q.ack;
	assign irq        = q.irq;
	assign dioOut     = q.dioOut;
	assign dioOe      = q.dioOe;
	assign davOut     = q.davOut;
	assign eoiOut     = q.eoiOut;
	assign accOut     = q.accOut;
	assign srqOut     = q.srq;
	assign devClr     = q.devClr;
	assign trigRun    = q.trig;
	assign remoteMode = q.remote;
	assign lockout    = q.lockout;
	assign rxData     = q.rxData;
	assign rxValid    = q.rxValid;
	assign rxLang     = q.lang;

	////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	a_dcl_clear: assert property (cmdNew && code == `GMR_C_DCL |=> devClr && !trigRun)
		else $error("device clear did not pulse");

	a_sdc_clear: assert property (cmdNew && code == `GMR_C_SDC |=> devClr == $past(q.listen))
		else $error("selected clear wrong");

	a_gtl_local: assert property (cmdNew && code == `GMR_C_GTL && q.listen |=> !remoteMode)
		else $error("go to local ignored");

	a_get_trigger: assert property (cmdNew && code == `GMR_C_GET && q.listen
		|=> trigRun == $past(seqProgrammed))
		else $error("trigger response wrong");

	a_ifc_quiet: assert property (q.s2.ifc |=> !q.listen && !q.talk ##1 !davOut)
		else $error("interface clear left bus active");

	a_llo_lock: assert property (cmdNew && code == `GMR_C_LLO && q.s2.ren |=> lockout)
		else $error("lockout not set");

	a_remote_cause: assert property ($rose(remoteMode) |-> $past(q.s2.ren) && q.listen)
		else $error("remote without enable and listen");

	a_spoll_byte: assert property (q.txPh == gmr_pkg::TX_STAT && !davOut && q.talk && !q.s2.atn
		&& !q.s2.acc && !q.s2.ifc && !ppoll |=> davOut && dioOut[7] == 1'b0 && eoiOut)
		else $error("status byte not offered");

	a_spd_off: assert property (cmdNew && code == `GMR_C_SPD |=> !q.spMode)
		else $error("serial poll not disabled");

	a_pp_drive: assert property (ppoll && q.ppCfg
		|=> dioOe == (8'h01 << $past(q.ppe[2:0])))
		else $error("parallel poll line not driven");

	a_ppu_off: assert property (cmdNew && code == `GMR_C_PPU |=> !q.ppCfg)
		else $error("parallel poll still configured");

	a_pp_silent: assert property (ppoll && !q.ppCfg |=> dioOe == 8'h00)
		else $error("parallel poll still answered");

	a_addr_range: assert property (q.addr >= `GMR_ADDR_MIN && q.addr <= `GMR_ADDR_MAX)
		else $error("address out of range");

	a_term_after: assert property (q.txPh == gmr_pkg::TX_DATA && q.txLast && q.davOut && q.s2.acc
		&& q.talk && !q.s2.atn && !q.s2.ifc |=> q.txPh == gmr_pkg::TX_CR)
		else $error("terminator skipped");

	a_term_cr: assert property (q.txPh == gmr_pkg::TX_CR && q.termCr && q.davOut && q.s2.acc
		&& q.talk && !q.s2.atn && !q.s2.ifc |=> q.txPh == gmr_pkg::TX_IDLE)
		else $error("line feed after CR only");

	a_dav_hold: assert property (davOut && !q.s2.acc && q.talk && !q.s2.atn && !q.s2.ifc
		|=> davOut)
		else $error("talker byte withdrawn before acceptance");

	a_rx_pulse: assert property (rxValid |=> !rxValid)
		else $error("received byte strobe too long");

	a_clr_pulse: assert property (devClr |=> !devClr)
		else $error("device clear pulse too long");

	a_irq_level: assert property (irq == |(q.irqSt & q.irqMask))
		else $error("interrupt level wrong");

	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge longer than one cycle");

	c_remote: cover property ($rose(remoteMode));
	c_spoll: cover property (q.txPh == gmr_pkg::TX_STAT && davOut);
	c_ppoll: cover property (ppoll && q.ppCfg);
	c_crlf: cover property (q.txPh == gmr_pkg::TX_LF && davOut);
	c_reject: cover property (q.irqSt[`GMR_I_REJ]);

endmodule : gpib_message_responder

//--- rtl/gmr_consts.svh
`ifndef GMR_CONSTS_SVH
`define GMR_CONSTS_SVH

// Register byte offsets.
`define GMR_A_CTRL 5'h00
`define GMR_A_STAT 5'h04
`define GMR_A_IRQ 5'h08
`define GMR_A_MASK 5'h0C
`define GMR_A_RESP 5'h10

// Control and response register fields, reset address and address limits.
`define GMR_F_TERM 8
`define GMR_F_LANG 9
`define GMR_F_LAST 8
`define GMR_R_ADDR 5'h05
`define GMR_ADDR_MIN 5'h01
`define GMR_ADDR_MAX 5'h1E

// Interrupt status bit positions.
`define GMR_I_CLR 0
`define GMR_I_TRIG 1
`define GMR_I_GTL 2
`define GMR_I_IFC 3
`define GMR_I_LLO 4
`define GMR_I_REJ 5

// Bus command codes seen with attention true, then the CR and LF data terminator bytes.
`define GMR_C_GTL 7'h01
`define GMR_C_SDC 7'h04
`define GMR_C_PPC 7'h05
`define GMR_C_GET 7'h08
`define GMR_C_LLO 7'h11
`define GMR_C_DCL 7'h14
`define GMR_C_PPU 7'h15
`define GMR_C_SPE 7'h18
`define GMR_C_SPD 7'h19
`define GMR_C_UNL 7'h3F
`define GMR_C_UNT 7'h5F
`define GMR_C_PPD 7'h70
`define GMR_CR 8'h0D
`define GMR_LF 8'h0A

`endif

//--- rtl/gmr_pkg.sv
package gmr_pkg;

	typedef enum logic [2:0] {TX_IDLE, TX_DATA, TX_CR, TX_LF, TX_STAT} txph_t;

	// Bus lines, high meaning true.
	typedef struct packed {
		logic [7:0] dio;
		logic       acc;
		logic       dav;
		logic       eoi;
		logic       ren;
		logic       ifc;
		logic       atn;
	} gpib_in_t;

	typedef struct packed {
		gpib_in_t    s1;
		gpib_in_t    s2;
		gpib_in_t    s3;
		logic        listen;
		logic        talk;
		logic        remote;
		logic        lockout;
		logic        spMode;
		logic        spSent;
		logic        ppCfg;
		logic        ppPend;
		logic [3:0]  ppe;
		logic [4:0]  addr;
		logic        termCr;
		logic        lang;
		logic [5:0]  irqSt;
		logic [5:0]  irqMask;
		logic        irq;
		logic        ack;
		logic [31:0] rdat;
		logic        devClr;
		logic        trig;
		logic [7:0]  rxData;
		logic        rxValid;
		logic        accOut;
		logic [7:0]  dioOut;
		logic [7:0]  dioOe;
		logic        davOut;
		logic        eoiOut;
		logic        srq;
		txph_t       txPh;
		logic [7:0]  txByte;
		logic        txLast;
	} state_t;

endpackage : gmr_pkg

//--- test/gpib_ctrl_model.sv
`timescale 1ns/1ps
module gpib_ctrl_model (
	input  wire logic         core_clk, // clock
	output gmr_pkg::gpib_in_t gpibIn,   // bus lines, true high
	input  wire logic [7:0]   dioOut,   // device data lines
	input  wire logic [7:0]   dioOe,    // device line enables
	input  wire logic         davOut,   // device data valid
	input  wire logic         eoiOut,   // device end mark
	input  wire logic         accOut    // device accepted byte
);
	initial gpibIn = '0;

	// A released data bus shows the inverse of the last byte.
	task automatic send(input logic a, input logic [7:0] b, output logic ok);
		int n;
		n = 0;
		@(posedge core_clk);
		gpibIn.atn <= a;
		gpibIn.dio <= b;
		gpibIn.dav <= 1'b1;
		do @(posedge core_clk); while (accOut !== 1'b1 && ++n < 64);
		ok = n < 64;
		gpibIn.dav <= 1'b0;
		gpibIn.dio <= ~b;
		do @(posedge core_clk); while (accOut !== 1'b0 && ++n < 128);
		repeat (3) @(posedge core_clk);
		gpibIn.atn <= 1'b0;
	endtask : send

	task automatic take(output logic [7:0] b, output logic e, output logic ok);
		int n;
		n = 0;
		do @(posedge core_clk); while (davOut !== 1'b1 && ++n < 64);
		b = dioOut;
		e = eoiOut;
		ok = n < 64 && dioOe === 8'hFF;
		gpibIn.acc <= 1'b1;
		do @(posedge core_clk); while (davOut !== 1'b0 && ++n < 128);
		gpibIn.acc <= 1'b0;
	endtask : take

	task automatic ppoll(output logic [7:0] oe, output logic [7:0] d);
		@(posedge core_clk);
		gpibIn.atn <= 1'b1;
		gpibIn.eoi <= 1'b1;
		repeat (6) @(negedge core_clk);
		oe = dioOe;
		d = dioOut;
		@(posedge core_clk);
		gpibIn.atn <= 1'b0;
		gpibIn.eoi <= 1'b0;
	endtask : ppoll

	// Remote enable is raised after the first listen address, before the device is addressed again.
	task automatic setRen(input logic v);
		@(posedge core_clk);
		gpibIn.ren <= v;
	endtask : setRen

	task automatic pulseIfc();
		@(posedge core_clk);
		gpibIn.ifc <= 1'b1;
		repeat (4) @(posedge core_clk);
		gpibIn.ifc <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask : pulseIfc
endmodule : gpib_ctrl_model

//--- test/gpib_message_responder_bench.sv
`timescale 1ns/1ps
`include "gmr_consts.svh"
module gpib_message_responder_bench;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [4:0] wb_adr_i = 5'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, irq, davOut, eoiOut, accOut, srqOut, devClr, trigRun;
	logic remoteMode, lockout, rxValid, rxLang;
	logic [7:0] dioOut, dioOe, rxData, lastRx, b, oe, d;
	gmr_pkg::gpib_in_t gpibIn;
	logic srvReq = 1'b0;
	logic [5:0] statIn = 6'h00;
	logic seqProgrammed = 1'b0;
	int n_fail = 0, compares = 0, nClr = 0, nTrig = 0, nRx = 0, cycles = 0, n0;
	logic [4:0] adr;
	logic [31:0] r;
	logic e, ok, t, s;
	logic [7:0] q[$];
	logic [2:0] l;

	gpib_message_responder dut (.core_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .gpibIn, .dioOut, .dioOe, .davOut,
		.eoiOut, .accOut, .srqOut, .srvReq, .statIn, .seqProgrammed, .devClr, .trigRun,
		.remoteMode, .lockout, .rxData, .rxValid, .rxLang);
	gpib_ctrl_model ctl (.core_clk, .gpibIn, .dioOut, .dioOe, .davOut, .eoiOut, .accOut);

	always #2 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cycles++;
		if (devClr === 1'b1) nClr++;
		if (trigRun === 1'b1) nTrig++;
		if (rxValid === 1'b1) begin
			nRx++;
			lastRx = rxData;
		end
		if (cycles == 20000) begin
			n_fail++;
			final_report();
		end
	end

	////////////////////////////////////////
	task automatic fail(input string m);
		n_fail++;
		$display("wrong value at %0t: %s", $time, m);
	endtask : fail

	task automatic chkw(input logic [31:0] g, input logic [31:0] x, input string m);
		compares++;
		if (g !== x) fail(m);
	endtask : chkw

	task automatic chkb(input logic g, input logic x, input string m);
		compares++;
		if (g !== x) fail(m);
	endtask : chkb

	function automatic logic [31:0] ctrlWord(logic [4:0] a, logic tm, logic lg);
		return {22'h0, lg, tm, 3'h0, a};
	endfunction : ctrlWord

	task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] dw);
		int n;
		n = 0;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= dw;
		wb_sel_i <= 4'hF;
		do @(posedge core_clk); while (wb_ack_o !== 1'b1 && ++n < 64);
		r = wb_dat_o;
		if (n >= 64) fail("no ack");
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task automatic cmd(input logic [7:0] c, input logic a = 1'b1);
		logic k;
		ctl.send(a, c, k);
		if (!k) fail("byte not accepted");
	endtask : cmd

	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : final_report

	////////////////////////////////////////
	initial begin
		r = $urandom(32'h3D67A4A8);
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		srvReq <= 1'($urandom);
		statIn <= 6'($urandom);
		wb(0, `GMR_A_CTRL, 0);
		chkw(r, ctrlWord(5'h05, 0, 0), "ctrl reset");
		wb(1, 5'h14, 32'hFFFFFFFF);
		wb(0, 5'h14, 0);
		chkw(r, 0, "unmapped read");
		$display("test reset done");
		q.delete();
		for (int i = 0; i < 5; i++) begin
			adr = i == 0 ? 5'h00 : i == 1 ? 5'h1F : i == 2 ? 5'h01 : i == 3 ? 5'h1E : 5'(1 + $urandom_range(29));
			wb(1, `GMR_A_CTRL, ctrlWord(adr, 0, 0));
			wb(0, `GMR_A_CTRL, 0);
			chkw(r, ctrlWord(i < 2 ? 5'h05 : adr, 0, 0), "address write");
			if (i == 1) begin
				wb(0, `GMR_A_IRQ, 0);
				chkw(r, 32'h20, "reject flag");
				chkb(irq, 0, "irq masked");
				wb(1, `GMR_A_MASK, 32'h20);
				repeat (2) @(posedge core_clk);
				chkb(irq, 1, "irq raised");
				wb(1, `GMR_A_IRQ, 32'h20);
				repeat (2) @(posedge core_clk);
				chkb(irq, 0, "irq cleared");
			end
		end
		$display("test address done");
		cmd({3'b001, adr});
		chkb(remoteMode, 0, "remote without enable");
		wb(0, `GMR_A_STAT, 0);
		chkw(r & 32'h4, 32'h4, "listen bit");
		ctl.setRen(1);
		cmd(`GMR_C_UNL);
		cmd({3'b001, adr});
		chkb(remoteMode, 1, "remote");
		for (int i = 0; i < 2; i++) begin
			wb(1, `GMR_A_CTRL, ctrlWord(adr, 0, i[0]));
			chkb(rxLang, i[0], "language");
			b = 8'($urandom);
			n0 = nRx;
			cmd(b, 0);
			chkw(nRx, n0 + 1, "rx count");
			chkw(lastRx, b, "rx data");
		end
		$display("test listen done");
		n0 = nTrig;
		cmd(`GMR_C_GET);
		seqProgrammed <= 1'b1;
		cmd(`GMR_C_GET);
		chkw(nTrig, n0 + 1, "trigger");
		cmd(`GMR_C_LLO);
		chkb(lockout, 1, "lockout");
		cmd(`GMR_C_GTL);
		chkb(remoteMode, 0, "go local");
		wb(0, `GMR_A_CTRL, 0);
		chkw(r, ctrlWord(adr, 0, 1), "settings kept");
		n0 = nClr;
		cmd(`GMR_C_DCL);
		chkw(nClr, n0 + 1, "device clear");
		cmd(`GMR_C_SDC);
		chkw(nClr, n0 + 2, "selected clear");
		ctl.pulseIfc();
		wb(0, `GMR_A_STAT, 0);
		chkw(r & 32'hC, 0, "ifc unaddress");
		cmd(`GMR_C_SDC);
		chkw(nClr, n0 + 2, "clear unaddressed");
		wb(0, `GMR_A_CTRL, 0);
		chkw(r, ctrlWord(adr, 0, 1), "ifc keeps settings");
		$display("test messages done");
		cmd({3'b010, adr});
		for (int i = 0; i < 2; i++) begin
			t = i[0];
			b = 8'($urandom);
			wb(1, `GMR_A_CTRL, ctrlWord(adr, t, 0));
			wb(1, `GMR_A_RESP, {23'h0, 1'b1, b});
			q = {b, `GMR_CR};
			if (!t) q.push_back(`GMR_LF);
			foreach (q[k]) begin
				ctl.take(d, e, ok);
				chkb(ok, 1, "talker handshake");
				chkw(d, q[k], "talker byte");
				chkb(e, k == q.size() - 1, "end mark");
			end
		end
		$display("test talker done");
		cmd(`GMR_C_UNT);
		srvReq <= 1'($urandom);
		statIn <= 6'($urandom);
		cmd(`GMR_C_SPE);
		cmd({3'b010, adr});
		ctl.take(d, e, ok);
		chkw(d, {1'b0, srvReq, statIn}, "status byte");
		chkb(srqOut, srvReq, "service line");
		cmd(`GMR_C_SPD);
		wb(0, `GMR_A_STAT, 0);
		chkw(r & 32'h10, 0, "poll mode off");
		$display("test serial poll done");
		cmd({3'b001, adr});
		for (int i = 0; i < 4; i++) begin
			l = 3'($urandom);
			s = 1'($urandom);
			srvReq <= 1'($urandom);
			cmd(`GMR_C_PPC);
			cmd({4'h6, s, l});
			ctl.ppoll(oe, d);
			chkw(oe, 8'h01 << l, "poll line");
			chkb(d[l], srvReq == s, "poll level");
		end
		cmd(`GMR_C_PPU);
		ctl.ppoll(oe, d);
		chkw(oe, 0, "poll off");
		$display("test parallel poll done");
		final_report();
	end
endmodule : gpib_message_responder_bench
